/* rtl/tccc_pkg.sv */
// Purpose: shared constants of the timer capture/compare control block
// Assumes: APB slave, one 32-bit word per register, byte address = index * 4
// Notes:   register data sits in the low bits, upper bits read as zero
package tccc_pkg;
  localparam int NUM_CH = 4;
  localparam int CNT_W = 16;
  localparam int PRE_STAGES = 7;
  localparam int ADDR_W = 12;
  // ==========================================================
  // register indices
  localparam logic [7:0] IDX_IO_SELECT = 8'hC0;
  localparam logic [7:0] IDX_CH3_MASK = 8'hC2;
  localparam logic [7:0] IDX_COUNTER = 8'hC4;
  localparam logic [7:0] IDX_SYS_CTRL_ONE = 8'hC6;
  localparam logic [7:0] IDX_OVF_TOGGLE = 8'hC7;
  localparam logic [7:0] IDX_PIN_ACTION = 8'hC8;
  localparam logic [7:0] IDX_EDGE_SELECT = 8'hC9;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'hCA;
  localparam logic [7:0] IDX_SYS_CTRL_TWO = 8'hCB;
  localparam logic [7:0] IDX_EVENT_FLAGS = 8'hCC;
  localparam logic [7:0] IDX_OVF_FLAG_REG = 8'hCD;
  localparam logic [7:0] IDX_CH_BASE = 8'hCE;
  localparam logic [7:0] IDX_CH_STRIDE = 8'h02;
  // ==========================================================
  // byte addresses
  localparam logic [ADDR_W-1:0] ADDR_IO_SELECT = {2'b00, IDX_IO_SELECT, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CH3_MASK = {2'b00, IDX_CH3_MASK, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_COUNTER = {2'b00, IDX_COUNTER, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_SYS_CTRL_ONE = {2'b00, IDX_SYS_CTRL_ONE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_OVF_TOGGLE = {2'b00, IDX_OVF_TOGGLE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PIN_ACTION = {2'b00, IDX_PIN_ACTION, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_EDGE_SELECT = {2'b00, IDX_EDGE_SELECT, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = {2'b00, IDX_IRQ_ENABLE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_SYS_CTRL_TWO = {2'b00, IDX_SYS_CTRL_TWO, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_EVENT_FLAGS = {2'b00, IDX_EVENT_FLAGS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_OVF_FLAG_REG = {2'b00, IDX_OVF_FLAG_REG, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CH_BASE = {2'b00, IDX_CH_BASE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CH_STRIDE = {2'b00, IDX_CH_STRIDE, 2'b00};
  // ==========================================================
  // field positions
  localparam int SC1_TIMER_EN_BIT = 7;
  localparam int SC1_FAST_CLR_BIT = 4;
  localparam int SC2_OVF_IRQ_BIT = 7;
  localparam int SC2_CNT_RST_BIT = 3;
  localparam int SC2_PRESCALE_LSB = 0;
  localparam int PRESCALE_W = 3;
  localparam int OVF_FLAG_BIT = 7;
  // ==========================================================
  // encodings and reset values
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_LOW = 2'h2;
  localparam logic [1:0] ACT_HIGH = 2'h3;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
endpackage

/* rtl/tccc_prescaler.sv */
// Purpose: bus clock divider giving the counter tick enable
// Assumes: divisor is two to the select value
// Notes:   a new select is taken only when every stage reads zero
`timescale 1ns/100ps
module tccc_prescaler #(
  parameter int STAGES = 7,
  parameter int SEL_W = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [SEL_W-1:0] select,
  output logic tick
);
  logic [STAGES-1:0] stage_reg;
  logic [SEL_W-1:0] active_sel_reg;
  logic [STAGES:0] full_mask;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_reg <= '0;
    end else if (!enable) begin
      stage_reg <= '0;
    end else begin
      stage_reg <= stage_reg + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_sel_reg <= '0;
    end else if (stage_reg == '0) begin
      active_sel_reg <= select;
    end
  end

  assign full_mask = ({{STAGES{1'b0}}, 1'b1} << active_sel_reg) - 1'b1;
  assign tick = enable && ((stage_reg & full_mask[STAGES-1:0]) == '0);

  property p_sel_hold;
    @(posedge pclk) disable iff (!presetn)
    stage_reg != '0 |=> $stable(active_sel_reg);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("prescale select changed mid count");
endmodule

/* rtl/tccc_edge_detect.sv */
// Purpose: input capture edge detector for one channel
// Assumes: pin is synchronous to pclk
// Notes:   pulse is one cycle wide, combinational from the stored level
`timescale 1ns/100ps
module tccc_edge_detect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  input wire logic [1:0] edge_select,
  output logic capture_pulse
);
  logic last_level_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_level_reg <= 1'b0;
    end else begin
      last_level_reg <= pin;
    end
  end

  // low bit rising, high bit falling
  assign capture_pulse = (edge_select[0] && pin && !last_level_reg) ||
                         (edge_select[1] && !pin && last_level_reg);
endmodule

/* rtl/tccc_top.sv */
// Purpose: timer control, flags, counter and four capture/compare channels
// Assumes: APB3 slave, no wait states (setup plus one access), 12-bit byte address
// Notes:   unmapped or unaligned addresses answer pslverr, writes ignored
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
module tccc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tccc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [tccc_pkg::NUM_CH-1:0] channel_pin_i,
  output logic [tccc_pkg::NUM_CH-1:0] channel_pin_o,
  output logic [tccc_pkg::NUM_CH-1:0] channel_pin_oe,
  output logic [tccc_pkg::NUM_CH-1:0] channel_irq,
  output logic overflow_irq
);
  localparam int N = tccc_pkg::NUM_CH;
  localparam int W = tccc_pkg::CNT_W;

  // ==========================================================
  // state
  logic [N-1:0] io_select_reg;
  logic [N-1:0] ch3_compare_mask_reg;
  logic timer_enable_reg;
  logic fast_flag_clear_reg;
  logic [N-1:0] overflow_toggle_en_reg;
  logic [2*N-1:0] compare_pin_action_reg;
  logic [2*N-1:0] capture_edge_select_reg;
  logic [N-1:0] channel_irq_en_reg;
  logic overflow_irq_en_reg;
  logic counter_reset_on_compare_en_reg;
  logic [tccc_pkg::PRESCALE_W-1:0] prescale_select_reg;
  logic [N-1:0] channel_event_flag_reg;
  logic overflow_flag_reg;
  logic [W-1:0] counter_reg;
  logic [W-1:0] channel_value_reg [N];
  logic [N-1:0] compare_output_line_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  logic tick;
  logic setup_phase;
  logic wr_en;
  logic rd_en;
  logic [N-1:0] chan_hit;
  logic [N-1:0] capture_evt;
  logic [N-1:0] match_evt;
  logic [N-1:0] capture_pulse;
  logic [N-1:0] ovf_toggle;
  logic ch3_reset;
  logic ovf_evt;
  logic [31:0] rdata_next;
  logic err_next;
  logic [N-1:0] ch_fast_clr;
  logic [N-1:0] ch_w1c;

  // ==========================================================
  // apb handshake
  // data only changes in setup so prdata comes straight from a flip-flop
  assign setup_phase = psel && !penable;
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite && !pslverr_reg;
  assign rd_en = psel && penable && !pwrite && !pslverr_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      assign chan_hit[g] = paddr ==
        tccc_pkg::ADDR_CH_BASE + tccc_pkg::ADDR_W'(g) * tccc_pkg::ADDR_CH_STRIDE;
      tccc_edge_detect u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .pin(channel_pin_i[g]),
        .edge_select(capture_edge_select_reg[2*g+1:2*g]),
        .capture_pulse(capture_pulse[g])
      );
      // capture only counts on input channels
      assign capture_evt[g] = capture_pulse[g] && !io_select_reg[g];
      assign match_evt[g] = tick && io_select_reg[g] && (counter_reg == channel_value_reg[g]);
      assign ovf_toggle[g] = ovf_evt && overflow_toggle_en_reg[g] && io_select_reg[g];
      assign ch_fast_clr[g] = fast_flag_clear_reg && chan_hit[g] &&
                              ((rd_en && !io_select_reg[g]) || (wr_en && io_select_reg[g]));
      assign ch_w1c[g] = wr_en && (paddr == tccc_pkg::ADDR_EVENT_FLAGS) && pwdata[g];
      assign channel_pin_oe[g] = |compare_pin_action_reg[2*g+1:2*g];
    end
  endgenerate

  // ==========================================================
  // read mux and decode
  always_comb begin
    rdata_next = '0;
    err_next = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      err_next = 1'b1;
    end else if (paddr == tccc_pkg::ADDR_IO_SELECT) begin
      rdata_next[N-1:0] = io_select_reg;
    end else if (paddr == tccc_pkg::ADDR_CH3_MASK) begin
      rdata_next[N-1:0] = ch3_compare_mask_reg;
    end else if (paddr == tccc_pkg::ADDR_COUNTER) begin
      rdata_next[W-1:0] = counter_reg;
    end else if (paddr == tccc_pkg::ADDR_SYS_CTRL_ONE) begin
      rdata_next[tccc_pkg::SC1_TIMER_EN_BIT] = timer_enable_reg;
      rdata_next[tccc_pkg::SC1_FAST_CLR_BIT] = fast_flag_clear_reg;
    end else if (paddr == tccc_pkg::ADDR_OVF_TOGGLE) begin
      rdata_next[N-1:0] = overflow_toggle_en_reg;
    end else if (paddr == tccc_pkg::ADDR_PIN_ACTION) begin
      rdata_next[2*N-1:0] = compare_pin_action_reg;
    end else if (paddr == tccc_pkg::ADDR_EDGE_SELECT) begin
      rdata_next[2*N-1:0] = capture_edge_select_reg;
    end else if (paddr == tccc_pkg::ADDR_IRQ_ENABLE) begin
      rdata_next[N-1:0] = channel_irq_en_reg;
    end else if (paddr == tccc_pkg::ADDR_SYS_CTRL_TWO) begin
      rdata_next[tccc_pkg::SC2_OVF_IRQ_BIT] = overflow_irq_en_reg;
      rdata_next[tccc_pkg::SC2_CNT_RST_BIT] = counter_reset_on_compare_en_reg;
      rdata_next[tccc_pkg::SC2_PRESCALE_LSB +: tccc_pkg::PRESCALE_W] = prescale_select_reg;
    end else if (paddr == tccc_pkg::ADDR_EVENT_FLAGS) begin
      rdata_next[N-1:0] = channel_event_flag_reg;
    end else if (paddr == tccc_pkg::ADDR_OVF_FLAG_REG) begin
      rdata_next[tccc_pkg::OVF_FLAG_BIT] = overflow_flag_reg;
    end else if (chan_hit != '0) begin
      for (int i = 0; i < N; i++) begin
        if (chan_hit[i]) begin
          rdata_next[W-1:0] = channel_value_reg[i];
        end
      end
    end else begin
      err_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rdata_next;
      pslverr_reg <= err_next;
    end
  end

  // ==========================================================
  // control registers
  // all control cleared at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_select_reg <= '0;
      ch3_compare_mask_reg <= '0;
      timer_enable_reg <= 1'b0;
      fast_flag_clear_reg <= 1'b0;
      overflow_toggle_en_reg <= '0;
      compare_pin_action_reg <= tccc_pkg::RESET_BYTE;
      capture_edge_select_reg <= tccc_pkg::RESET_BYTE;
      channel_irq_en_reg <= '0;
      overflow_irq_en_reg <= 1'b0;
      counter_reset_on_compare_en_reg <= 1'b0;
      prescale_select_reg <= '0;
    end else if (wr_en) begin
      if (paddr == tccc_pkg::ADDR_IO_SELECT) begin
        io_select_reg <= pwdata[N-1:0];
      end else if (paddr == tccc_pkg::ADDR_CH3_MASK) begin
        ch3_compare_mask_reg <= pwdata[N-1:0];
      end else if (paddr == tccc_pkg::ADDR_SYS_CTRL_ONE) begin
        timer_enable_reg <= pwdata[tccc_pkg::SC1_TIMER_EN_BIT];
        fast_flag_clear_reg <= pwdata[tccc_pkg::SC1_FAST_CLR_BIT];
      end else if (paddr == tccc_pkg::ADDR_OVF_TOGGLE) begin
        overflow_toggle_en_reg <= pwdata[N-1:0];
      end else if (paddr == tccc_pkg::ADDR_PIN_ACTION) begin
        compare_pin_action_reg <= pwdata[2*N-1:0];
      end else if (paddr == tccc_pkg::ADDR_EDGE_SELECT) begin
        capture_edge_select_reg <= pwdata[2*N-1:0];
      end else if (paddr == tccc_pkg::ADDR_IRQ_ENABLE) begin
        channel_irq_en_reg <= pwdata[N-1:0];
      end else if (paddr == tccc_pkg::ADDR_SYS_CTRL_TWO) begin
        overflow_irq_en_reg <= pwdata[tccc_pkg::SC2_OVF_IRQ_BIT];
        counter_reset_on_compare_en_reg <= pwdata[tccc_pkg::SC2_CNT_RST_BIT];
        prescale_select_reg <= pwdata[tccc_pkg::SC2_PRESCALE_LSB +: tccc_pkg::PRESCALE_W];
      end
    end
  end

  // ==========================================================
  // prescaler and counter
  tccc_prescaler #(
    .STAGES(tccc_pkg::PRE_STAGES),
    .SEL_W(tccc_pkg::PRESCALE_W)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .enable(timer_enable_reg),
    .select(prescale_select_reg),
    .tick(tick)
  );

  assign ch3_reset = counter_reset_on_compare_en_reg && match_evt[3];
  assign ovf_evt = tick && (counter_reg == tccc_pkg::CNT_MAX) && !ch3_reset;

  // a software write wins over the tick; the first period after it may be short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_reg <= tccc_pkg::CNT_ZERO;
    end else if (wr_en && paddr == tccc_pkg::ADDR_COUNTER) begin
      counter_reg <= pwdata[W-1:0];
    end else if (ch3_reset) begin
      counter_reg <= tccc_pkg::CNT_ZERO;
    end else if (tick) begin
      counter_reg <= counter_reg + 1'b1;
    end
  end

  // channel values: capture latches, software writes compare values only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) begin
        channel_value_reg[i] <= tccc_pkg::CNT_ZERO;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        if (capture_evt[i]) begin
          channel_value_reg[i] <= counter_reg;
        end else if (wr_en && chan_hit[i] && io_select_reg[i]) begin
          channel_value_reg[i] <= pwdata[W-1:0];
        end
      end
    end
  end

  // ==========================================================
  // compare output lines
  // masked channels belong to channel-3 data transfer, so their field is ignored on a match but still drives channel_pin_oe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_output_line_reg <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (ovf_toggle[i]) begin
          compare_output_line_reg[i] <= !compare_output_line_reg[i];
        end else if (match_evt[i] && !ch3_compare_mask_reg[i]) begin
          case (compare_pin_action_reg[2*i+1 -: 2])
            tccc_pkg::ACT_TOGGLE: compare_output_line_reg[i] <= !compare_output_line_reg[i];
            tccc_pkg::ACT_LOW: compare_output_line_reg[i] <= 1'b0;
            tccc_pkg::ACT_HIGH: compare_output_line_reg[i] <= 1'b1;
            default: compare_output_line_reg[i] <= compare_output_line_reg[i];
          endcase
        end
      end
    end
  end
  assign channel_pin_o = compare_output_line_reg;

  // ==========================================================
  // flags and requests, a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_event_flag_reg <= '0;
    end else begin
      channel_event_flag_reg <= (channel_event_flag_reg & ~(ch_w1c | ch_fast_clr)) |
                                capture_evt | match_evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_reg <= 1'b0;
    end else if (ovf_evt) begin
      overflow_flag_reg <= 1'b1;
    end else if (wr_en && paddr == tccc_pkg::ADDR_OVF_FLAG_REG &&
                 pwdata[tccc_pkg::OVF_FLAG_BIT]) begin
      overflow_flag_reg <= 1'b0;
    end else if (fast_flag_clear_reg && (rd_en || wr_en) &&
                 paddr == tccc_pkg::ADDR_COUNTER) begin
      overflow_flag_reg <= 1'b0;
    end
  end

  assign channel_irq = channel_event_flag_reg & channel_irq_en_reg;
  assign overflow_irq = overflow_flag_reg && overflow_irq_en_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_tov_toggle;
    ovf_evt && overflow_toggle_en_reg[0] && io_select_reg[0]
      |=> channel_pin_o[0] != $past(channel_pin_o[0]);
  endproperty
  a_tov_toggle: assert property (p_tov_toggle) else $error("overflow toggle missed");

  property p_tov_capture;
    ovf_evt && !io_select_reg[1] |=> $stable(channel_pin_o[1]);
  endproperty
  a_tov_capture: assert property (p_tov_capture) else $error("capture pin toggled");

  property p_act_low;
    match_evt[2] && !ovf_toggle[2] && !ch3_compare_mask_reg[2] &&
      compare_pin_action_reg[5:4] == tccc_pkg::ACT_LOW |=> !channel_pin_o[2];
  endproperty
  a_act_low: assert property (p_act_low) else $error("drive low action failed");

  property p_pin_oe;
    compare_pin_action_reg[1:0] != tccc_pkg::ACT_OFF |-> channel_pin_oe[0];
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin not output");

  property p_chan_irq;
    capture_evt[0] && channel_irq_en_reg[0] |=> channel_irq[0];
  endproperty
  a_chan_irq: assert property (p_chan_irq) else $error("channel request missing");

  property p_hold_zero;
    counter_reset_on_compare_en_reg && io_select_reg[3] && tick &&
      channel_value_reg[3] == tccc_pkg::CNT_ZERO && counter_reg == tccc_pkg::CNT_ZERO &&
      !(wr_en && paddr == tccc_pkg::ADDR_COUNTER) |=> counter_reg == tccc_pkg::CNT_ZERO;
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("counter left zero");

  property p_no_ovf_max;
    ch3_reset && counter_reg == tccc_pkg::CNT_MAX && !overflow_flag_reg |=> !overflow_flag_reg;
  endproperty
  a_no_ovf_max: assert property (p_no_ovf_max) else $error("overflow set on reset");

  property p_flag_set;
    match_evt[1] |=> channel_event_flag_reg[1];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event flag not set");

  property p_w1c;
    ch_w1c[0] && !capture_evt[0] && !match_evt[0] |=> !channel_event_flag_reg[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");

  property p_ovf_set;
    ovf_evt |=> overflow_flag_reg ##1 (overflow_flag_reg || $past(wr_en || rd_en));
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag lost");

  c_capture: cover property (capture_evt[0] ##1 channel_event_flag_reg[0]);
  c_compare: cover property (match_evt[1] && io_select_reg[1]);
  c_overflow: cover property (ovf_evt ##1 overflow_irq);
  c_fast_clr: cover property (ch_fast_clr[2] && channel_event_flag_reg[2]);
endmodule

/* tb/tccc_top_bench.sv */
// Purpose: self-checking bench for the timer capture/compare control block
// Assumes: APB answers after setup plus one access cycle, pins synchronous
// Notes:   rows cover plain control registers, hand tests cover the rest
`timescale 1ns/100ps
module tccc_top_bench;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [tccc_pkg::ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic er;
  logic [3:0] pin_i = 4'h0;
  logic [3:0] pin_o;
  logic [3:0] pin_oe;
  logic [3:0] ch_irq;
  logic ovf_irq;
  int error_cnt = 0;
  int n_compared = 0;
  logic [11:0] ra [4] = '{tccc_pkg::ADDR_EDGE_SELECT, tccc_pkg::ADDR_IRQ_ENABLE,
                          tccc_pkg::ADDR_OVF_TOGGLE, tccc_pkg::ADDR_PIN_ACTION};
  logic [7:0] rw [4] = '{8'hA5, 8'hFF, 8'hFF, 8'h5A};
  logic [7:0] re [4] = '{8'hA5, 8'h0F, 8'h0F, 8'h5A};
  always #5 pclk = ~pclk;
  tccc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .channel_pin_i(pin_i), .channel_pin_o(pin_o),
    .channel_pin_oe(pin_oe), .channel_irq(ch_irq), .overflow_irq(ovf_irq));
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let the access edge settle so callers compare updated outputs
    @(negedge pclk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, {24'h0, e});
  endtask
  task automatic poll(input logic [11:0] a, input logic [7:0] m);
    for (int i = 0; i < 100; i++) begin
      apb(1'b0, a, 32'h0);
      if ((rd[7:0] & m) !== 8'h00) break;
    end
  endtask
  task automatic pin(input logic [3:0] v);
    @(posedge pclk);
    pin_i <= v;
    repeat (3) @(posedge pclk);
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========================================================
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    error_cnt++;
    summarize();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rdchk(ra[i], 8'h00);
      apb(1'b1, ra[i], {24'h0, rw[i]});
      rdchk(ra[i], re[i]);
    end
    apb(1'b0, 12'hFFC, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("register table done");
    apb(1'b1, tccc_pkg::ADDR_EDGE_SELECT, 32'h01);
    apb(1'b1, tccc_pkg::ADDR_IRQ_ENABLE, 32'h01);
    apb(1'b1, tccc_pkg::ADDR_PIN_ACTION, 32'h00);
    apb(1'b1, tccc_pkg::ADDR_OVF_TOGGLE, 32'h00);
    chk({28'h0, ch_irq}, 32'h0);
    pin(4'h1);
    chk({28'h0, ch_irq}, 32'h1);
    apb(1'b1, tccc_pkg::ADDR_EVENT_FLAGS, 32'h00);
    rdchk(tccc_pkg::ADDR_EVENT_FLAGS, 8'h01);
    apb(1'b1, tccc_pkg::ADDR_EVENT_FLAGS, 32'h01);
    rdchk(tccc_pkg::ADDR_EVENT_FLAGS, 8'h00);
    chk({28'h0, ch_irq}, 32'h0);
    $display("capture done");
    apb(1'b1, tccc_pkg::ADDR_SYS_CTRL_ONE, 32'h10);
    pin(4'h0);
    pin(4'h1);
    rdchk(tccc_pkg::ADDR_EVENT_FLAGS, 8'h01);
    apb(1'b0, tccc_pkg::ADDR_CH_BASE, 32'h0);
    rdchk(tccc_pkg::ADDR_EVENT_FLAGS, 8'h00);
    $display("fast clear done");
    apb(1'b1, tccc_pkg::ADDR_CH3_MASK, 32'h00);
    apb(1'b1, tccc_pkg::ADDR_IO_SELECT, 32'h02);
    apb(1'b1, tccc_pkg::ADDR_CH_BASE + tccc_pkg::ADDR_CH_STRIDE, 32'h0005);
    apb(1'b1, tccc_pkg::ADDR_PIN_ACTION, 32'h0C);
    chk({28'h0, pin_oe}, 32'h2);
    apb(1'b1, tccc_pkg::ADDR_SYS_CTRL_TWO, 32'h80);
    apb(1'b1, tccc_pkg::ADDR_COUNTER, 32'h0000);
    apb(1'b1, tccc_pkg::ADDR_SYS_CTRL_ONE, 32'h80);
    poll(tccc_pkg::ADDR_EVENT_FLAGS, 8'h02);
    chk(rd & 32'h2, 32'h2);
    chk({31'h0, pin_o[1]}, 32'h1);
    $display("compare done");
    apb(1'b1, tccc_pkg::ADDR_COUNTER, 32'hFFF0);
    poll(tccc_pkg::ADDR_OVF_FLAG_REG, 8'h80);
    chk(rd, 32'h80);
    chk({31'h0, ovf_irq}, 32'h1);
    apb(1'b1, tccc_pkg::ADDR_OVF_FLAG_REG, 32'h80);
    rdchk(tccc_pkg::ADDR_OVF_FLAG_REG, 8'h00);
    chk({31'h0, ovf_irq}, 32'h0);
    $display("overflow done");
    apb(1'b1, tccc_pkg::ADDR_CH_BASE + tccc_pkg::ADDR_CH_STRIDE, 32'hFFFF);
    apb(1'b1, tccc_pkg::ADDR_OVF_TOGGLE, 32'h03);
    apb(1'b1, tccc_pkg::ADDR_COUNTER, 32'hFFF0);
    poll(tccc_pkg::ADDR_OVF_FLAG_REG, 8'h80);
    chk({30'h0, pin_o[1:0]}, 32'h0);
    apb(1'b1, tccc_pkg::ADDR_OVF_TOGGLE, 32'h00);
    apb(1'b1, tccc_pkg::ADDR_OVF_FLAG_REG, 32'h80);
    apb(1'b1, tccc_pkg::ADDR_IO_SELECT, 32'h0A);
    apb(1'b1, tccc_pkg::ADDR_CH_BASE + 12'h3 * tccc_pkg::ADDR_CH_STRIDE, 32'hFFFF);
    apb(1'b1, tccc_pkg::ADDR_SYS_CTRL_TWO, 32'h88);
    apb(1'b1, tccc_pkg::ADDR_COUNTER, 32'hFFF0);
    repeat (40) @(posedge pclk);
    rdchk(tccc_pkg::ADDR_OVF_FLAG_REG, 8'h00);
    apb(1'b1, tccc_pkg::ADDR_CH_BASE + 12'h3 * tccc_pkg::ADDR_CH_STRIDE, 32'h0010);
    apb(1'b1, tccc_pkg::ADDR_COUNTER, 32'h0000);
    repeat (40) @(posedge pclk);
    apb(1'b0, tccc_pkg::ADDR_COUNTER, 32'h0);
    chk({31'h0, rd[15:0] <= 16'h0010}, 32'h1);
    apb(1'b1, tccc_pkg::ADDR_CH_BASE + 12'h3 * tccc_pkg::ADDR_CH_STRIDE, 32'h0000);
    apb(1'b1, tccc_pkg::ADDR_COUNTER, 32'h0000);
    repeat (5) @(posedge pclk);
    rdchk(tccc_pkg::ADDR_COUNTER, 8'h00);
    $display("counter reset done");
    apb(1'b1, tccc_pkg::ADDR_SYS_CTRL_TWO, 32'h80);
    apb(1'b1, tccc_pkg::ADDR_COUNTER, 32'hFFF0);
    poll(tccc_pkg::ADDR_OVF_FLAG_REG, 8'h80);
    chk(rd, 32'h80);
    apb(1'b1, tccc_pkg::ADDR_SYS_CTRL_ONE, 32'h90);
    apb(1'b0, tccc_pkg::ADDR_COUNTER, 32'h0);
    rdchk(tccc_pkg::ADDR_OVF_FLAG_REG, 8'h00);
    apb(1'b1, tccc_pkg::ADDR_SYS_CTRL_ONE, 32'h80);
    $display("counter fast clear done");
    apb(1'b1, tccc_pkg::ADDR_SYS_CTRL_TWO, 32'h03);
    // a new divisor waits for the stages to pass zero, at most 128 cycles
    repeat (130) @(posedge pclk);
    apb(1'b1, tccc_pkg::ADDR_COUNTER, 32'h0000);
    repeat (80) @(posedge pclk);
    apb(1'b0, tccc_pkg::ADDR_COUNTER, 32'h0);
    chk({31'h0, rd[15:0] >= 16'h000A && rd[15:0] <= 16'h000B}, 32'h1);
    $display("prescale done");
    apb(1'b1, tccc_pkg::ADDR_EDGE_SELECT, 32'h20);
    pin(4'h5);
    apb(1'b0, tccc_pkg::ADDR_EVENT_FLAGS, 32'h0);
    chk(rd & 32'h4, 32'h0);
    pin(4'h1);
    apb(1'b0, tccc_pkg::ADDR_EVENT_FLAGS, 32'h0);
    chk(rd & 32'h4, 32'h4);
    $display("falling edge done");
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    chk({17'h0, pready, pslverr, ovf_irq, ch_irq, pin_oe, pin_o}, 32'h4000);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(tccc_pkg::ADDR_SYS_CTRL_TWO, 8'h00);
    rdchk(tccc_pkg::ADDR_EVENT_FLAGS, 8'h00);
    $display("reset done");
    summarize();
  end
endmodule
